/* File: nfc_pkg.sv */
// constants and types for the nand flash host controller
package nfc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // strobe phase lengths, at least the slow variant's 70 ns byte cycle
    localparam int STROBE_LOW_NS = 35;
    localparam int STROBE_HIGH_NS = 35;
    localparam logic [3:0] STROBE_LOW_CYC =
        4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] STROBE_HIGH_CYC =
        4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // output access delay before sampling read data
    localparam int OUTPUT_ACCESS_DELAY_NS = 45;
    localparam logic [3:0] OUTPUT_ACCESS_DELAY_CYC =
        4'((OUTPUT_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // wait from last write strobe until busy is valid
    localparam int BUSY_SETTLE_NS = 150;
    localparam logic [3:0] BUSY_SETTLE_CYC =
        4'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CMD_READ_LO = 8'h00;
    localparam logic [7:0] CMD_READ_HI = 8'h01;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_EXEC = 8'hD0;
    localparam logic [9:0] PAGE_MAIN_BYTES = 10'd512;
    localparam logic [9:0] PAGE_FULL_BYTES = 10'd528;
    localparam logic [9:0] HALF_PAGE_BYTES = 10'd256;
    typedef enum logic [1:0] {
        NFC_OP_READ,
        NFC_OP_PROG,
        NFC_OP_ERASE
    } nfc_op_e;
    typedef enum logic [1:0] {
        NFC_BK_CMD,
        NFC_BK_ADDR,
        NFC_BK_WDATA,
        NFC_BK_RDATA
    } nfc_beat_e;
endpackage : nfc_pkg

/* File: nfc_buf2.sv */
// two-entry valid/ready buffer for read data
`timescale 1ns/1ps
`default_nettype none
module nfc_buf2 (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // fill side
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [7:0] mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_q != 2'd2;
    assign out_valid = cnt_q != 2'd0;
    assign out_data = mem_q[rp_q];
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule // nfc_buf2
`default_nettype wire

/* File: nfc_host.sv */
// host controller driving a nand flash device through its pins
// How it works
// - command beat: command select high, strobe rises
// - address beat: address select high, strobe rises
// - address sent column, middle, high byte
// - read strobe no faster than 70 ns
// - program and erase use two commands
// - erase sends only two row bytes
// - write data taken on strobe rise
`timescale 1ns/1ps
`default_nettype none
module nfc_host (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // operation request
    input wire logic op_valid,
    input wire logic [1:0] op_kind,
    input wire logic op_half,
    input wire logic [23:0] op_addr,
    input wire logic [9:0] op_len,
    output logic op_ready,
    output logic op_done,
    // program data source
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    // read data sink
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    // flash pins
    output logic chip_sel_n,
    output logic cmd_latch,
    output logic addr_latch,
    output logic write_strobe_n,
    output logic output_strobe_n,
    output logic prog_lock_n,
    output logic spare_en_n,
    input wire logic [7:0] shared_bus_i,
    output logic [7:0] shared_bus_o,
    output logic [7:0] shared_bus_oe,
    input wire logic ready_busy_i,
    // static controls
    input wire logic allow_write,
    input wire logic read_spare
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOW, ST_HIGH, ST_WAIT, ST_NEXT
    } nfc_state_e;
    nfc_state_e st_q;
    nfc_pkg::nfc_beat_e beat_q;
    nfc_pkg::nfc_op_e op_q;
    logic [3:0] tmr_q;
    logic [1:0] step_q;
    logic [23:0] addr_q;
    logic half_q;
    logic [9:0] cnt_q;
    logic [7:0] cap_q;
    logic cap_v_q;
    logic cs_n_q, cle_q, ale_q, we_n_q, re_n_q, lock_n_q, spare_n_q;
    logic [7:0] bo_q;
    logic oe_q;
    logic done_q;
    logic rdy_q;
    logic buf_ready;

    function automatic logic [3:0] dec(input logic [3:0] v);
        dec = (v == 4'd0) ? 4'd0 : 4'(v - 4'd1);
    endfunction

    // address byte order, bit 8 never sent
    wire [7:0] addr_byte0 = addr_q[7:0];
    wire [7:0] addr_byte1 = addr_q[16:9];
    // top address byte carries seven bits; its msb is sent low
    wire [7:0] addr_byte2 = {1'b0, addr_q[23:17]};
    wire is_erase = op_q == nfc_pkg::NFC_OP_ERASE;
    wire is_read = op_q == nfc_pkg::NFC_OP_READ;
    // erase skips the column byte
    wire [1:0] addr_first = is_erase ? 2'd1 : 2'd0;
    wire [7:0] addr_sel = (step_q == 2'd0) ? addr_byte0 :
        (step_q == 2'd1) ? addr_byte1 : addr_byte2;
    wire [7:0] read_cmd = half_q ? nfc_pkg::CMD_READ_HI
        : nfc_pkg::CMD_READ_LO;
    wire [7:0] setup_cmd = is_read ? read_cmd : is_erase ?
        nfc_pkg::CMD_ERASE_SETUP : nfc_pkg::CMD_PROG_SETUP;
    wire [7:0] exec_cmd = is_erase ? nfc_pkg::CMD_ERASE_EXEC
        : nfc_pkg::CMD_PROG_EXEC;
    wire [7:0] cmd_sel = (step_q == 2'd0) ? setup_cmd : exec_cmd;
    // read data stall: no strobe while buffer is full
    wire rd_go = buf_ready && !cap_v_q;
    wire data_go = (beat_q == nfc_pkg::NFC_BK_RDATA) ? rd_go : wr_valid;
    wire tmr_zero = tmr_q == 4'd0;
    wire last_data = cnt_q == 10'd1;
    wire busy_seen = !ready_busy_i;
    wire start_ok = op_valid && rdy_q && ready_busy_i;
    // a write beat is anything other than a read data beat
    wire wr_beat = beat_q != nfc_pkg::NFC_BK_RDATA;
    wire [7:0] beat_byte = (beat_q == nfc_pkg::NFC_BK_CMD) ? cmd_sel :
        (beat_q == nfc_pkg::NFC_BK_ADDR) ? addr_sel : wr_data;

    nfc_buf2 u_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_data(cap_q),
        .in_valid(cap_v_q),
        .in_ready(buf_ready),
        .out_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready)
    );

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            beat_q <= nfc_pkg::NFC_BK_CMD;
            op_q <= nfc_pkg::NFC_OP_READ;
            tmr_q <= 4'd0;
            step_q <= 2'd0;
            addr_q <= 24'h000000;
            half_q <= 1'b0;
            cnt_q <= 10'd0;
            rdy_q <= 1'b0;
        end else begin
            tmr_q <= dec(tmr_q);
            unique case (st_q)
                ST_IDLE: begin
                    rdy_q <= ready_busy_i;
                    if (start_ok) begin
                        rdy_q <= 1'b0;
                        op_q <= nfc_pkg::nfc_op_e'(op_kind);
                        addr_q <= op_addr;
                        half_q <= op_half;
                        // length of every operation kind capped at one full page
                        cnt_q <= (op_len > nfc_pkg::PAGE_FULL_BYTES) ?
                            nfc_pkg::PAGE_FULL_BYTES : op_len;
                        beat_q <= nfc_pkg::NFC_BK_CMD;
                        step_q <= 2'd0;
                        st_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (beat_q == nfc_pkg::NFC_BK_CMD ||
                        beat_q == nfc_pkg::NFC_BK_ADDR || data_go) begin
                        tmr_q <= wr_beat ? nfc_pkg::STROBE_LOW_CYC
                            : nfc_pkg::OUTPUT_ACCESS_DELAY_CYC;
                        st_q <= ST_LOW;
                    end
                end
                ST_LOW: if (tmr_zero) begin
                    tmr_q <= nfc_pkg::STROBE_HIGH_CYC;
                    st_q <= ST_HIGH;
                end
                ST_HIGH: if (tmr_zero) begin
                    st_q <= ST_NEXT;
                    unique case (beat_q)
                        nfc_pkg::NFC_BK_CMD:
                            if (step_q == 2'd1) begin
                                tmr_q <= nfc_pkg::BUSY_SETTLE_CYC;
                                st_q <= ST_WAIT;
                            end else begin
                                beat_q <= nfc_pkg::NFC_BK_ADDR;
                                step_q <= addr_first;
                            end
                        nfc_pkg::NFC_BK_ADDR:
                            if (step_q == 2'd2) begin
                                step_q <= 2'd0;
                                if (is_read) begin
                                    tmr_q <= nfc_pkg::BUSY_SETTLE_CYC;
                                    st_q <= ST_WAIT;
                                end else if (is_erase) begin
                                    beat_q <= nfc_pkg::NFC_BK_CMD;
                                    step_q <= 2'd1;
                                end else
                                    beat_q <= nfc_pkg::NFC_BK_WDATA;
                            end else
                                step_q <= 2'(step_q + 2'd1);
                        default: begin
                            cnt_q <= 10'(cnt_q - 10'd1);
                            if (last_data) begin
                                st_q <= is_read ? ST_IDLE : ST_NEXT;
                                beat_q <= nfc_pkg::NFC_BK_CMD;
                                step_q <= 2'd1;
                            end
                        end
                    endcase
                end
                ST_WAIT: if (tmr_zero && !busy_seen) begin
                    // array read done: stream data; else op complete
                    if (is_read && beat_q == nfc_pkg::NFC_BK_ADDR) begin
                        beat_q <= nfc_pkg::NFC_BK_RDATA;
                        st_q <= (cnt_q == 10'd0) ? ST_IDLE : ST_NEXT;
                    end else
                        st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // pin drivers, all registered
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cs_n_q <= 1'b1;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            bo_q <= 8'h00;
            oe_q <= 1'b0;
            lock_n_q <= 1'b0;
            spare_n_q <= 1'b1;
            cap_q <= 8'h00;
            cap_v_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            lock_n_q <= allow_write;
            spare_n_q <= !read_spare;
            // chip select held through busy; deselect only in idle
            cs_n_q <= st_q == ST_IDLE;
            cle_q <= st_q != ST_IDLE && st_q != ST_WAIT &&
                beat_q == nfc_pkg::NFC_BK_CMD;
            ale_q <= st_q != ST_IDLE && st_q != ST_WAIT &&
                beat_q == nfc_pkg::NFC_BK_ADDR;
            we_n_q <= !(st_q == ST_LOW && wr_beat);
            re_n_q <= !(st_q == ST_LOW && !wr_beat);
            bo_q <= beat_byte;
            // only drive while writing; read beats leave bus to device
            oe_q <= (st_q == ST_LOW || st_q == ST_HIGH) && wr_beat;
            cap_v_q <= 1'b0;
            if (st_q == ST_LOW && tmr_zero && !wr_beat) begin
                cap_q <= shared_bus_i;
                cap_v_q <= 1'b1;
            end
            done_q <= st_q != ST_IDLE && st_q != ST_NEXT &&
                ((st_q == ST_WAIT && tmr_zero && !busy_seen &&
                !(is_read && beat_q == nfc_pkg::NFC_BK_ADDR &&
                cnt_q != 10'd0)) ||
                (st_q == ST_HIGH && tmr_zero && is_read && last_data &&
                beat_q == nfc_pkg::NFC_BK_RDATA));
        end
    end

    assign chip_sel_n = cs_n_q;
    assign cmd_latch = cle_q;
    assign addr_latch = ale_q;
    assign write_strobe_n = we_n_q;
    assign output_strobe_n = re_n_q;
    assign prog_lock_n = lock_n_q;
    assign spare_en_n = spare_n_q;
    assign shared_bus_o = bo_q;
    assign shared_bus_oe = {8{oe_q}};
    assign op_ready = rdy_q;
    assign op_done = done_q;
    // write byte consumed at end of each program data beat
    assign wr_ready = st_q == ST_HIGH && tmr_zero &&
        beat_q == nfc_pkg::NFC_BK_WDATA;
endmodule // nfc_host
`default_nettype wire

/* File: nfc_flash_model.sv */
// behavioural flash device answering the host controller's pins
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
    parameter int T_RD = 2000,
    parameter int T_PROG = 5000,
    parameter int T_ERASE = 8000
) (
    // control pins
    input wire logic chip_sel_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic output_strobe_n,
    input wire logic prog_lock_n,
    input wire logic spare_en_n,
    // shared bus and ready/busy pull-down
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic bus_oe,
    output logic rb_low
);
    logic [7:0] mem [int];
    logic [7:0] pg [528];
    logic [7:0] cmd = 8'hFF;
    logic [7:0] last = 8'h00;
    logic half = 1'h0;
    logic busy = 1'h0;
    int row = 0;
    int col = 0;
    int n = 0;
    int idx;
    int b;
    assign bus_oe = !chip_sel_n && !output_strobe_n;
    // released bus shows the inverse, never a stale copy
    assign bus_out = bus_oe ? last : ~last;
    assign rb_low = busy;
    task automatic go(input int t);
        busy = 1'h1;
        #t;
        busy = 1'h0;
    endtask
    // busy times are scaled down to keep the run short
    always @(posedge write_strobe_n) if (!chip_sel_n && !busy) begin
        if (cmd_latch) begin
            cmd = bus_in;
            n = 0;
            if (cmd < 8'h02) half = cmd[0];
            if (cmd == 8'h80) pg = '{default: 8'hFF};
            if (cmd == 8'h10 && prog_lock_n) begin
                for (int c = 0; c < 528; c++)
                    if (pg[c] != 8'hFF) mem[row * 528 + c] = pg[c];
                go(T_PROG);
            end
            if (cmd == 8'hD0 && prog_lock_n) begin
                b = (row & ~31) * 528;
                for (int k = b; k < b + 16896; k++) mem.delete(k);
                go(T_ERASE);
            end
        end else if (addr_latch) begin
            idx = n + int'(cmd == 8'h60);
            if (idx == 0) col = {half, bus_in};
            if (idx == 1) row[7:0] = bus_in;
            if (idx == 2) row[14:8] = bus_in[6:0];
            if (idx < 3) n++;
            if (idx == 2 && cmd < 8'h02) go(T_RD);
        end else if (cmd == 8'h80 && col < 528) begin
            pg[col] = bus_in;
            col++;
        end
    end
    always @(negedge output_strobe_n) if (!chip_sel_n && !busy) begin
        last = mem.exists(row * 528 + col) ? mem[row * 528 + col] : 8'hFF;
        half = 1'h0;
        col++;
        if (col == (spare_en_n ? 512 : 528)) begin
            col = 0;
            row++;
        end
    end
endmodule // nfc_flash_model
`default_nettype wire

/* File: nfc_host_chk.sv */
// assertions on the host controller's flash pins
`timescale 1ns/1ps
`default_nettype none
module nfc_host_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // watched ports
    input wire logic op_ready,
    input wire logic chip_sel_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic output_strobe_n,
    input wire logic [7:0] shared_bus_oe,
    input wire logic ready_busy_i
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence wr_fall_s; $fell(write_strobe_n); endsequence
    sequence rd_fall_s; $fell(output_strobe_n); endsequence
    sequence rd_rise_s; $rose(output_strobe_n); endsequence
    sels_apart_a: assert property (!(cmd_latch && addr_latch))
        else $error("both latch selects high");
    wr_low_hold_a: assert property (wr_fall_s |=> !write_strobe_n)
        else $error("write strobe low too short");
    rd_low_hold_a: assert property (rd_fall_s |=> !output_strobe_n)
        else $error("output strobe low too short");
    rd_high_hold_a: assert property (rd_rise_s |=> output_strobe_n)
        else $error("output strobe high too short");
    wr_bus_drive_a: assert property (
        !write_strobe_n |-> shared_bus_oe == 8'hFF)
        else $error("bus not driven during write strobe");
    rd_bus_free_a: assert property (
        !output_strobe_n |-> shared_bus_oe == 8'h00)
        else $error("bus driven during read strobe");
    strobe_select_a: assert property (
        (!write_strobe_n || !output_strobe_n) |-> !chip_sel_n)
        else $error("strobe without chip select");
    latch_steady_a: assert property (
        (!write_strobe_n && !$past(write_strobe_n))
        |-> $stable(cmd_latch) && $stable(addr_latch))
        else $error("latch select moved under strobe");
    busy_hold_a: assert property (
        (!ready_busy_i && !$past(ready_busy_i)) |-> !op_ready)
        else $error("ready while flash busy");
    busy_select_a: assert property (!ready_busy_i |-> !chip_sel_n)
        else $error("chip select dropped while busy");
endmodule // nfc_host_chk
bind nfc_host nfc_host_chk chk (.clk_sys(clk_sys), .resetn(resetn),
    .op_ready(op_ready), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .shared_bus_oe(shared_bus_oe),
    .ready_busy_i(ready_busy_i));
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench: host controller against a flash device model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic op_valid = 1'h0, op_half = 1'h0, wr_valid = 1'h0, rd_ready = 1'h0;
    logic allow_write = 1'h1, read_spare = 1'h0, saw_busy = 1'h0;
    logic [1:0] op_kind = 2'h0;
    logic [23:0] op_addr = 24'h0;
    logic [9:0] op_len = 10'h0;
    logic [7:0] wr_data = 8'h00, rd_data, bo, boe, bi, m_out;
    logic op_ready, op_done, wr_ready, rd_valid, m_oe, m_rb;
    logic cs_n, cl, al, ws_n, os_n, lock_n, spare_n;
    logic [7:0] shadow [int];
    int failures = 0, checks_done = 0, seed = 32'hA9122389, r, n;
    // per-bit resolution: host enable wins, else the device side
    assign bi = (boe & bo) | (~boe & m_out);
    always #12.5 clk_sys = !clk_sys;
    always @(posedge m_rb) saw_busy = 1'h1;
    nfc_host dut (.clk_sys(clk_sys), .resetn(resetn), .op_valid(op_valid),
        .op_kind(op_kind), .op_half(op_half), .op_addr(op_addr),
        .op_len(op_len), .op_ready(op_ready), .op_done(op_done),
        .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .chip_sel_n(cs_n), .cmd_latch(cl), .addr_latch(al),
        .write_strobe_n(ws_n), .output_strobe_n(os_n), .prog_lock_n(lock_n),
        .spare_en_n(spare_n), .shared_bus_i(bi), .shared_bus_o(bo),
        .shared_bus_oe(boe), .ready_busy_i(!m_rb),
        .allow_write(allow_write), .read_spare(read_spare));
    nfc_flash_model flash (.chip_sel_n(cs_n), .cmd_latch(cl),
        .addr_latch(al), .write_strobe_n(ws_n), .output_strobe_n(os_n),
        .prog_lock_n(lock_n), .spare_en_n(spare_n), .bus_in(bi),
        .bus_out(m_out), .bus_oe(m_oe), .rb_low(m_rb));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one operation; the read stream is checked as it drains
    task automatic run_op(input logic [1:0] k, input logic h, input int rr,
                          input int c, input int len);
        int i, j, t, pc, pr, e;
        logic dn, tk, wt, rt;
        i = 0;
        j = 0;
        t = 0;
        dn = 1'h0;
        pr = rr;
        pc = {h, 8'(c)};
        op_kind = k;
        op_half = h;
        op_addr = {15'(rr), 1'h0, 8'(c)};
        op_len = 10'(len);
        op_valid = 1'h1;
        wr_valid = (k == 2'h1);
        wr_data = 8'(rr * 7) ^ 8'h5A;
        saw_busy = 1'h0;
        while (!(dn && (k != 2'h0 || i >= len)) && t < 20000) begin
            @(negedge clk_sys);
            tk = op_valid && op_ready;
            wt = wr_valid && wr_ready;
            rt = rd_valid && rd_ready;
            dn = dn || op_done;
            if (rt) begin
                e = shadow.exists(pr * 528 + pc) ? shadow[pr * 528 + pc] : 255;
                check(rd_data, 8'(e));
                i++;
                pc++;
                if (pc == (read_spare ? 528 : 512)) begin
                    pc = 0;
                    pr++;
                end
            end
            @(posedge clk_sys);
            #2;
            if (tk) op_valid = 1'h0;
            if (wt) begin
                if (allow_write) shadow[rr * 528 + j] = wr_data;
                j++;
                wr_data = 8'((rr + j) * 7) ^ 8'h5A;
                wr_valid = (j < len);
            end
            rd_ready = 1'($random(seed));
            t++;
        end
        if (t >= 20000) failures++;
        check({7'h0, saw_busy}, {7'h0, allow_write || k == 2'h0});
    endtask
    initial begin
        #(25 * 100000);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        check({cs_n, lock_n, spare_n, op_ready, 4'h0} | boe, 8'hA0);
        #2;
        resetn = 1'h1;
        repeat (2) @(posedge clk_sys);
        #2;
        for (int s = 0; s < 3; s++) begin
            r = ($random(seed) & 32'h3FF) * 32;
            n = (s == 0) ? 528 : 1 + ($random(seed) & 32'h1FF);
            read_spare = s[0];
            run_op(2'h1, 1'h0, r, 0, n);
            run_op(2'h0, 1'h0, r, $random(seed) & 32'hFF, 12);
            run_op(2'h0, 1'h1, r, 250, 12);
            run_op(2'h2, 1'h0, r, 0, 0);
            for (int q = r * 528; q < (r + 32) * 528; q++) shadow.delete(q);
            run_op(2'h0, 1'h0, r, 0, 4);
            allow_write = 1'h0;
            run_op(2'h1, 1'h0, r, 0, 4);
            run_op(2'h0, 1'h0, r, 0, 4);
            allow_write = 1'h1;
        end
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
